// ---- src/cdr_regs.sv ----
// Charger-detect status and control register bank with its serial slave
// and a small detection sequencer. Assumes the analog front end supplies
// comparator, contact and classifier levels asynchronously on pins.
`timescale 1ns/1ps
`default_nettype none
`include "cdr_consts.svh"

// Behaviour
// - Detect-enable starts detection on bus change
// - Status bits 7:5 report charger type code
// - Bit 4 shows comparator; any change interrupts
// - Bit 2 timeout after 2s; rising interrupts
// - Bit 1 running flag, never interrupts
// - Contact-enable set: short test after contact
// - Contact-enable clear: skip straight to short
// - Clearing contact-enable while stuck bypasses contact
// - Suspend bit picks disabled-charger output levels
// - Override makes outputs follow written field
// - Output field loaded from result unless overridden
// - Compliance bit steers plain-cable output choice
// - Regulated-output enable clear keeps supply off
// - Timing bit: on at completion or valid bus
// - Exit bit leaves detection on timeout
// - Control reset values are design parameters, except manual, mask and method bits
// - Serial-less variant changes three reset values
// - Status read clears pending; mask only hides
module cdr_regs import cdr_pkg::*; #(
    parameter bit          SERIAL_VARIANT = 1'b1,
    parameter int unsigned CONTACT_TIMEOUT_CYC = `CDR_CONTACT_TMO_CYC,
    parameter bit          RST_DETECT_EN  = `CDR_RST_DETECT_EN,
    parameter bit          RST_CONTACT_EN = `CDR_RST_CONTACT_EN,
    parameter bit          RST_SUSPEND    = `CDR_RST_SUSPEND,
    parameter bit          RST_OVERRIDE   = `CDR_RST_OVERRIDE,
    parameter logic [2:0]  RST_CE_FIELD   = `CDR_RST_CE_FIELD,
    parameter bit          RST_COMPLIANCE = `CDR_RST_COMPLIANCE,
    parameter bit          RST_REG_EN     = `CDR_RST_REG_EN,
    parameter bit          RST_REG_TIMING = `CDR_RST_REG_TIMING,
    parameter bit          RST_EXIT       = `CDR_RST_EXIT
) (
    input  wire logic       CLK,             // 250 MHz clock
    input  wire logic       RESET,           // async, active high
    input  wire logic       SCL_IN,          // serial clock pin
    input  wire logic       SDA_IN,          // serial data pin level
    output logic            SDA_OUT,         // serial data drive value
    output logic            SDA_OE,          // high while pulling SDA
    input  wire logic       VBUS_COMP_IN,    // bus at/above threshold
    input  wire logic       CONTACT_IN,      // data contact sensed
    input  wire logic [2:0] CLASS_IN,        // classifier type code
    output logic [2:0]      CE_OUT,          // charger enables, 2..0
    output logic [2:0]      CE_OE,           // high while pulling low
    output logic            SUPPLY_ON,       // transceiver supply on
    output logic            INT_N            // interrupt, active low
);

    // the serial-less variant resets three controls differently.
    localparam bit RST_SUS = SERIAL_VARIANT ? RST_SUSPEND : 1'b1;
    localparam bit RST_CPL = SERIAL_VARIANT ? RST_COMPLIANCE : 1'b0;
    localparam bit RST_REN = SERIAL_VARIANT ? RST_REG_EN : 1'b1;

    logic [6:0]  sync1_r;
    logic [6:0]  sync2_r;
    logic        scl_d_r;
    logic        sda_d_r;
    logic        det_en_r;
    logic        manual_r;
    logic        mask_r;
    logic        contact_en_r;
    logic        suspend_r;
    logic        override_r;
    logic [2:0]  ce_r;
    logic        cdp_r;
    logic        cpl_r;
    logic        reg_en_r;
    logic        reg_timing_r;
    logic        exit_r;
    logic [2:0]  type_r;
    logic        vbus_r;
    logic        timeout_r;
    logic [1:0]  pend_r;
    logic        complete_r;
    logic [31:0] contact_cnt_r;
    cdr_det_type det_st;
    cdr_bus_type bus_st;
    logic [3:0]  bit_cnt_r;
    logic [7:0]  shift_r;
    logic [7:0]  ptr_r;
    logic        wr_stb;
    logic        rd_stb;
    logic [7:0]  rd_data;
    logic        det_start;
    logic        det_finish;
    logic [2:0]  ce_fsm;

    wire scl     = sync2_r[0];
    wire sda     = sync2_r[1];
    wire vbus_s  = sync2_r[2];
    wire contact = sync2_r[3];
    wire [2:0] class_s = sync2_r[6:4];
    wire scl_rise = scl & ~scl_d_r;
    wire scl_fall = ~scl & scl_d_r;
    wire bus_start = scl & scl_d_r & sda_d_r & ~sda;
    wire bus_stop  = scl & scl_d_r & ~sda_d_r & sda;
    wire timed_out = contact_cnt_r >= CONTACT_TIMEOUT_CYC;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            sync1_r <= 7'h03;
            sync2_r <= 7'h03;
            scl_d_r <= 1'h1;
            sda_d_r <= 1'h1;
        end else begin
            sync1_r <= {CLASS_IN, CONTACT_IN, VBUS_COMP_IN, SDA_IN, SCL_IN};
            sync2_r <= sync1_r;
            scl_d_r <= scl;
            sda_d_r <= sda;
        end
    end

    // Serial slave: sample on SCL rise, change SDA on SCL fall.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            bus_st    <= BUS_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r   <= 8'h00;
            ptr_r     <= 8'h00;
            SDA_OE    <= 1'h0;
        end else if (bus_start) begin
            bus_st    <= BUS_ADDR;
            // The SCL fall that closes START wraps this count to zero.
            bit_cnt_r <= 4'hF;
            SDA_OE    <= 1'h0;
        end else if (bus_stop) begin
            bus_st <= BUS_IDLE;
            SDA_OE <= 1'h0;
        end else if (scl_rise && bit_cnt_r < 4'h8 && bus_st != BUS_RD) begin
            shift_r <= {shift_r[6:0], sda};
        end else if (scl_rise && bit_cnt_r == 4'h8 && bus_st == BUS_RD
                     && sda) begin
            bus_st <= BUS_IDLE;
        end else if (scl_fall && bus_st != BUS_IDLE) begin
            if (bit_cnt_r == 4'h7) begin
                bit_cnt_r <= 4'h8;
                SDA_OE    <= bus_st != BUS_RD
                             && (bus_st != BUS_ADDR
                                 || shift_r[7:1] == `CDR_SLAVE_ADDR);
                if (bus_st == BUS_ADDR && shift_r[7:1] != `CDR_SLAVE_ADDR)
                    bus_st <= BUS_IDLE;
                if (bus_st == BUS_REG)
                    ptr_r <= shift_r;
                if (bus_st == BUS_WR)
                    ptr_r <= ptr_r + 8'h01;
            end else if (bit_cnt_r == 4'h8) begin
                bit_cnt_r <= 4'h0;
                case (bus_st)
                    BUS_ADDR: bus_st <= shift_r[0] ? BUS_RD : BUS_REG;
                    BUS_REG:  bus_st <= BUS_WR;
                    default:  bus_st <= bus_st;
                endcase
                if (bus_st == BUS_RD || (bus_st == BUS_ADDR && shift_r[0]))
                begin
                    shift_r <= rd_data;
                    ptr_r   <= ptr_r + 8'h01;
                    SDA_OE  <= ~rd_data[7];
                end else begin
                    SDA_OE <= 1'h0;
                end
            end else begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
                if (bus_st == BUS_RD) begin
                    shift_r <= {shift_r[6:0], 1'h0};
                    SDA_OE  <= ~shift_r[6];
                end
            end
        end
    end

    assign wr_stb = scl_fall && bus_st == BUS_WR && bit_cnt_r == 4'h7;
    assign rd_stb = scl_fall && bit_cnt_r == 4'h8
                    && (bus_st == BUS_RD || (bus_st == BUS_ADDR && shift_r[0]));

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET)
            SDA_OUT <= 1'h0;
        else
            SDA_OUT <= 1'h0;
    end

    // Reserved bits read zero and status is never written.
    always_comb begin
        case (ptr_r)
            `CDR_OFS_CTRL_ONE:   rd_data = {1'h0, mask_r, 4'h0, manual_r,
                                            det_en_r};
            `CDR_OFS_STATUS:     rd_data = {type_r, vbus_r, 1'h0, timeout_r,
                                            ~det_st[0], 1'h0};
            `CDR_OFS_CTRL_TWO:   rd_data = {contact_en_r, 2'h0, suspend_r,
                                            override_r, ce_r};
            `CDR_OFS_CTRL_THREE: rd_data = {3'h0, cdp_r, cpl_r, reg_en_r,
                                            reg_timing_r, exit_r};
            default:             rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            det_en_r     <= RST_DETECT_EN;
            manual_r     <= 1'h0;
            mask_r       <= 1'h0;
            contact_en_r <= RST_CONTACT_EN;
            suspend_r    <= RST_SUS;
            override_r   <= RST_OVERRIDE;
            cdp_r        <= 1'h0;
            cpl_r        <= RST_CPL;
            reg_en_r     <= RST_REN;
            reg_timing_r <= RST_REG_TIMING;
            exit_r       <= RST_EXIT;
        end else if (wr_stb) begin
            if (det_finish)
                manual_r <= 1'h0;
            case (ptr_r)
                `CDR_OFS_CTRL_ONE: begin
                    det_en_r <= shift_r[`CDR_C1_DETECT_EN];
                    manual_r <= shift_r[`CDR_C1_MANUAL];
                    mask_r   <= shift_r[`CDR_C1_MASK];
                end
                `CDR_OFS_CTRL_TWO: begin
                    contact_en_r <= shift_r[`CDR_C2_CONTACT_EN];
                    suspend_r    <= shift_r[`CDR_C2_SUSPEND];
                    override_r   <= shift_r[`CDR_C2_OVERRIDE];
                end
                `CDR_OFS_CTRL_THREE: begin
                    cdp_r        <= shift_r[`CDR_C3_DS_METHOD];
                    cpl_r        <= shift_r[`CDR_C3_COMPLIANCE];
                    reg_en_r     <= shift_r[`CDR_C3_REG_EN];
                    reg_timing_r <= shift_r[`CDR_C3_REG_TIMING];
                    exit_r       <= shift_r[`CDR_C3_EXIT];
                end
                default: mask_r <= mask_r;
            endcase
        end else if (det_finish) begin
            manual_r <= 1'h0;
        end
    end

    // Detection sequencer: contact phase, short test, then done.
    assign det_start  = det_st == DET_IDLE
                        && ((det_en_r && vbus_s != vbus_r) || manual_r);
    assign det_finish = det_st == DET_DONE
                        || (det_st == DET_CONTACT && timed_out && exit_r);

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            det_st        <= DET_IDLE;
            contact_cnt_r <= 32'h0;
            type_r        <= 3'h0;
        end else begin
            case (det_st)
                DET_IDLE: begin
                    contact_cnt_r <= 32'h0;
                    if (det_start)
                        det_st <= DET_CONTACT;
                end
                DET_CONTACT: begin
                    if (!contact_en_r || contact)
                        det_st <= DET_SHORT;
                    else if (timed_out && exit_r)
                        det_st <= DET_IDLE;
                    else if (!timed_out)
                        contact_cnt_r <= contact_cnt_r + 32'h1;
                end
                DET_SHORT: begin
                    type_r <= class_s;
                    det_st <= DET_DONE;
                end
                DET_DONE: det_st <= DET_IDLE;
                default:  det_st <= DET_IDLE;
            endcase
        end
    end

    // A status read clears pending events, but a new event wins.
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            vbus_r    <= 1'h0;
            timeout_r <= 1'h0;
            pend_r    <= 2'h0;
            INT_N     <= 1'h1;
        end else begin
            vbus_r    <= vbus_s;
            timeout_r <= det_st == DET_CONTACT && timed_out;
            pend_r[0] <= (vbus_s != vbus_r)
                         || (pend_r[0] && !(rd_stb && ptr_r == `CDR_OFS_STATUS));
            pend_r[1] <= (det_st == DET_CONTACT && timed_out && !timeout_r)
                         || (pend_r[1] && !(rd_stb && ptr_r == `CDR_OFS_STATUS));
            INT_N     <= ~(mask_r && |pend_r);
        end
    end

    // Outputs after detection, per charger type, with suspend picking enabled or disabled levels.
    always_comb begin
        case (type_r)
            3'h1:    ce_fsm = !cpl_r ? 3'h4 : (suspend_r ? 3'h1 : 3'h7);
            3'h2:    ce_fsm = 3'h2;
            3'h3:    ce_fsm = 3'h2;
            3'h4:    ce_fsm = 3'h4;
            3'h5:    ce_fsm = 3'h2;
            3'h7:    ce_fsm = 3'h0;
            default: ce_fsm = suspend_r ? 3'h1 : 3'h7;
        endcase
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ce_r       <= RST_CE_FIELD;
            CE_OUT     <= 3'h7;
            CE_OE      <= 3'h0;
            complete_r <= 1'h0;
            SUPPLY_ON  <= 1'h0;
        end else begin
            // The byte that turns the override on also loads its field.
            if (wr_stb && ptr_r == `CDR_OFS_CTRL_TWO
                && shift_r[`CDR_C2_OVERRIDE])
                ce_r <= shift_r[2:0];
            else if (!override_r)
                ce_r <= ce_fsm;
            CE_OUT     <= ce_r;
            CE_OE      <= ~ce_r;
            complete_r <= vbus_s && (complete_r || det_st == DET_DONE);
            SUPPLY_ON  <= reg_en_r && (reg_timing_r ? vbus_s : complete_r);
        end
    end

    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);

    no_start_off_a: assert property (det_st == DET_IDLE && !det_en_r
        && !manual_r |=> det_st == DET_IDLE) else $error("detection started");
    vbus_event_a: assert property ($changed(vbus_r) |-> pend_r[0])
        else $error("comparator change not pending");
    timeout_event_a: assert property ($rose(timeout_r) |-> pend_r[1])
        else $error("timeout rise not pending");
    skip_contact_a: assert property (det_st == DET_CONTACT
        && !contact_en_r |=> det_st == DET_SHORT)
        else $error("contact phase not skipped");
    wait_contact_a: assert property (det_st == DET_CONTACT
        && contact_en_r && !contact |=> det_st != DET_SHORT)
        else $error("short too early");
    override_hold_a: assert property (override_r && !wr_stb
        |=> $stable(ce_r)) else $error("overridden field changed");
    ce_drive_a: assert property (1'b1 |=> CE_OE == ~$past(ce_r))
        else $error("enable outputs wrong");
    supply_off_a: assert property (!reg_en_r |=> !SUPPLY_ON)
        else $error("supply on while disabled");
    exit_timeout_a: assert property (det_st == DET_CONTACT
        && contact_en_r && !contact && timed_out && exit_r
        |=> det_st == DET_IDLE) else $error("no exit on timeout");
    mask_hide_a: assert property (!mask_r |=> INT_N)
        else $error("masked interrupt shown");

    det_done_c: cover property (det_st == DET_SHORT ##1 det_st == DET_DONE);
    status_rd_c: cover property (rd_stb && ptr_r == `CDR_OFS_STATUS);
    ctrl_wr_c: cover property (wr_stb && ptr_r == `CDR_OFS_CTRL_TWO);

endmodule
`default_nettype wire

// ---- src/cdr_consts.svh ----
// Register offsets, field positions, reset values and timing counts for the
// charger-detect register bank. Included by the bank and its package users.
`ifndef CDR_CONSTS_SVH
`define CDR_CONSTS_SVH

`define CDR_OFS_CTRL_ONE     8'h01
`define CDR_OFS_STATUS       8'h02
`define CDR_OFS_CTRL_TWO     8'h03
`define CDR_OFS_CTRL_THREE   8'h04

`define CDR_C1_DETECT_EN     0
`define CDR_C1_MANUAL        1
`define CDR_C1_MASK          6
`define CDR_C2_CONTACT_EN    7
`define CDR_C2_SUSPEND       4
`define CDR_C2_OVERRIDE      3
`define CDR_C3_DS_METHOD     4
`define CDR_C3_COMPLIANCE    3
`define CDR_C3_REG_EN        2
`define CDR_C3_REG_TIMING    1
`define CDR_C3_EXIT          0

`define CDR_RST_DETECT_EN    1'h1
`define CDR_RST_CONTACT_EN   1'h1
`define CDR_RST_SUSPEND      1'h0
`define CDR_RST_OVERRIDE     1'h0
`define CDR_RST_CE_FIELD     3'h0
`define CDR_RST_COMPLIANCE   1'h1
`define CDR_RST_REG_EN       1'h0
`define CDR_RST_REG_TIMING   1'h1
`define CDR_RST_EXIT         1'h1

// Arbitrary neutral serial-bus slave address.
`define CDR_SLAVE_ADDR       7'h35

`define CDR_CLK_MHZ          250
`define CDR_CONTACT_TMO_MS   2000
`define CDR_CONTACT_TMO_CYC  (`CDR_CONTACT_TMO_MS * 1000 * `CDR_CLK_MHZ)

`endif

// ---- src/cdr_pkg.sv ----
// Types shared by the charger-detect register bank.
// Assumes cdr_consts.svh supplies all numeric constants.
package cdr_pkg;

    typedef enum logic [3:0] {
        DET_IDLE    = 4'b0001,
        DET_CONTACT = 4'b0010,
        DET_SHORT   = 4'b0100,
        DET_DONE    = 4'b1000
    } cdr_det_type;

    typedef enum logic [4:0] {
        BUS_IDLE = 5'b00001,
        BUS_ADDR = 5'b00010,
        BUS_REG  = 5'b00100,
        BUS_WR   = 5'b01000,
        BUS_RD   = 5'b10000
    } cdr_bus_type;

endpackage

// ---- test/cdr_host_model.sv ----
// Serial host model: an open-drain master on the register bus of the
// charger-detect bank. Assumes the bench resolves SDA from all enables.
`timescale 1ns/1ps
`default_nettype none
`include "cdr_consts.svh"
module cdr_host_model (
    input  wire logic clk,      // bench clock
    input  wire logic sda_line, // resolved SDA level
    output var  logic scl,      // serial clock, idles high
    output var  logic sda_drv   // 0 pulls SDA low, 1 releases it
);
    initial begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Half periods of eleven clocks keep well above the slave's minimum of eight.
    task automatic put_bit(input logic b, output logic seen);
        @(posedge clk) sda_drv <= b;
        wait_clk(5);
        @(posedge clk) scl <= 1'b1;
        wait_clk(8);
        seen = sda_line;
        wait_clk(2);
        @(posedge clk) scl <= 1'b0;
        wait_clk(4);
    endtask
    task automatic start_cond();
        @(posedge clk) sda_drv <= 1'b1;
        wait_clk(5);
        @(posedge clk) scl <= 1'b1;
        wait_clk(9);
        @(posedge clk) sda_drv <= 1'b0;
        wait_clk(9);
        @(posedge clk) scl <= 1'b0;
        wait_clk(4);
    endtask
    task automatic stop_cond();
        @(posedge clk) sda_drv <= 1'b0;
        wait_clk(5);
        @(posedge clk) scl <= 1'b1;
        wait_clk(9);
        @(posedge clk) sda_drv <= 1'b1;
        wait_clk(9);
    endtask
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], s);
        end
        put_bit(1'b1, s);
        ack = ~s;
    endtask
    // The closing NACK tells the slave that the read is over.
    task automatic get_byte(output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, s);
            d[i] = s;
        end
        put_bit(1'b1, s);
    endtask
    task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d,
                             output logic ok);
        logic a0, a1, a2;
        start_cond();
        put_byte({`CDR_SLAVE_ADDR, 1'b0}, a0);
        put_byte(ofs, a1);
        put_byte(d, a2);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask
    // Pending events are cleared only by reading the status register.
    task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
        logic a0, a1, a2;
        start_cond();
        put_byte({`CDR_SLAVE_ADDR, 1'b0}, a0);
        put_byte(ofs, a1);
        start_cond();
        put_byte({`CDR_SLAVE_ADDR, 1'b1}, a2);
        get_byte(d);
        stop_cond();
    endtask
endmodule
`default_nettype wire

// ---- test/charger_detect_status_control_regs_tb_top.sv ----
// Self-checking bench for the charger-detect register bank.
// Assumes the host model drives the serial bus; SDA and the charger
// enable lines have pull-ups, resolved here from every enable.
`timescale 1ns/1ps
`default_nettype none
module charger_detect_status_control_regs_tb_top;
    logic       clk, reset, vbus, contact, scl, host_sda;
    logic [2:0] class_code;
    logic       sda_out, sda_oe, supply_on, int_n;
    logic [2:0] ce_out, ce_oe;
    int         mismatches = 0;
    int         n_tests = 0;
    wire logic       sda_line = host_sda & ~sda_oe;
    wire logic [2:0] ce_line  = ~ce_oe;

    // A short timeout keeps the run brief but outlasts one register read.
    cdr_regs #(.CONTACT_TIMEOUT_CYC(4000)) dut (
        .CLK(clk), .RESET(reset), .SCL_IN(scl), .SDA_IN(sda_line),
        .SDA_OUT(sda_out), .SDA_OE(sda_oe), .VBUS_COMP_IN(vbus),
        .CONTACT_IN(contact), .CLASS_IN(class_code), .CE_OUT(ce_out),
        .CE_OE(ce_oe), .SUPPLY_ON(supply_on), .INT_N(int_n));
    cdr_host_model host (
        .clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(host_sda));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
        logic ok;
        host.write_reg(ofs, d, ok);
    endtask
    task automatic rd_chk(input logic [7:0] ofs, exp, msk);
        logic [7:0] d;
        host.read_reg(ofs, d);
        check(d & msk, exp);
    endtask
    task automatic chk_ce(input logic [2:0] e);
        check({2'h0, ce_out, ce_line}, {2'h0, e, e});
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic test_reset();
        rd_chk(8'h03, 8'h87, 8'hFF);
        rd_chk(8'h04, 8'h0B, 8'hFF);
        rd_chk(8'h02, 8'h00, 8'hFF);
        rd_chk(8'h07, 8'h00, 8'hFF);
        chk_ce(3'b111);
        check({7'h0, sda_out}, 8'h00);
        check({7'h0, supply_on}, 8'h00);
        $display("test_reset done");
    endtask
    task automatic test_override();
        wr(8'h02, 8'hFF);
        rd_chk(8'h02, 8'h00, 8'hFF);
        wr(8'h03, 8'hEA);
        rd_chk(8'h03, 8'h8A, 8'hFF);
        chk_ce(3'b010);
        wr(8'h03, 8'h90);
        rd_chk(8'h03, 8'h91, 8'hFF);
        chk_ce(3'b001);
        wr(8'h03, 8'h80);
        $display("test_override done");
    endtask
    task automatic test_detect();
        @(posedge clk) class_code <= 3'b011;
        @(posedge clk) vbus <= 1'b1;
        rd_chk(8'h02, 8'h12, 8'hFF);
        @(posedge clk) contact <= 1'b1;
        wait_clk(20);
        rd_chk(8'h02, 8'h70, 8'hFF);
        chk_ce(3'b010);
        check({7'h0, supply_on}, 8'h00);
        wr(8'h04, 8'h0F);
        check({7'h0, supply_on}, 8'h01);
        $display("test_detect done");
    endtask
    task automatic test_stuck();
        wr(8'h04, 8'h0E);
        @(posedge clk) contact <= 1'b0;
        class_code <= 3'b100;
        wr(8'h01, 8'h03);
        wait_clk(4100);
        check({7'h0, int_n}, 8'h01);
        wr(8'h01, 8'h41);
        check({7'h0, int_n}, 8'h00);
        rd_chk(8'h02, 8'h76, 8'hFF);
        check({7'h0, int_n}, 8'h01);
        // Software clears contact detection while it is stuck.
        wr(8'h03, 8'h00);
        rd_chk(8'h02, 8'h90, 8'hFB);
        chk_ce(3'b100);
        $display("test_stuck done");
    endtask
    task automatic test_exit();
        @(posedge clk) class_code <= 3'b001;
        wr(8'h01, 8'h43);
        rd_chk(8'h02, 8'h30, 8'hFB);
        chk_ce(3'b111);
        wr(8'h04, 8'h07);
        chk_ce(3'b100);
        wr(8'h03, 8'h80);
        wr(8'h01, 8'h43);
        wait_clk(4100);
        rd_chk(8'h02, 8'h00, 8'h02);
        $display("test_exit done");
    endtask
    task automatic test_disabled();
        wr(8'h01, 8'h40);
        @(posedge clk) vbus <= 1'b0;
        wait_clk(20);
        @(posedge clk) vbus <= 1'b1;
        wait_clk(20);
        check({7'h0, int_n}, 8'h00);
        rd_chk(8'h02, 8'h10, 8'h12);
        check({7'h0, supply_on}, 8'h01);
        // With late timing the supply waits for a finished detection.
        wr(8'h04, 8'h05);
        check({7'h0, supply_on}, 8'h00);
        @(posedge clk) contact <= 1'b1;
        wr(8'h01, 8'h42);
        wait_clk(20);
        check({7'h0, supply_on}, 8'h01);
        $display("test_disabled done");
    endtask

    initial begin
        reset      = 1'b1;
        vbus       = 1'b0;
        contact    = 1'b0;
        class_code = 3'h0;
        wait_clk(12);
        reset <= 1'b0;
        wait_clk(6);
        test_reset();
        test_override();
        test_detect();
        test_stuck();
        test_exit();
        test_disabled();
        end_of_test();
    end
    // The tests take about 31,000 clocks; this limit leaves a wide margin.
    initial begin
        wait_clk(90000);
        mismatches++;
        end_of_test();
    end
endmodule
`default_nettype wire
